// ===== srcal_pkg.sv
package srcal_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_ENABLE = 12'h2b0;
  localparam logic [11:0] IDX_CONFIG = 12'h2b1;
  localparam logic [11:0] IDX_RESULT = 12'h2b2;
  localparam logic [11:0] IDX_MANUAL = 12'h2b5;
  localparam logic [11:0] IDX_RAMP   = 12'h2b8;
  localparam logic [11:0] IDX_IRQ_ST = 12'h2c8;
  localparam logic [11:0] IDX_IRQ_CL = 12'h2c9;
  localparam logic [11:0] IDX_IRQ_EN = 12'h2ca;
  localparam logic [11:0] IDX_SYSREF = 12'h2cb;

  // values after reset
  localparam logic [7:0]  RST_ENABLE = 8'h00;
  localparam logic [7:0]  RST_CONFIG = 8'h05;
  localparam logic [23:0] RST_MANUAL = 24'h000000;
  localparam logic [7:0]  RST_RAMP   = 8'h00;

  // field positions
  localparam int AVG_LSB  = 2;
  localparam int HDUR_LSB = 0;
  localparam int DONE_BIT = 17;
  localparam int DELAY_W  = 17;

  // calibration length constants
  localparam logic [15:0] BOUND_BASE = 16'h1300; // 256 x 19
  localparam logic [14:0] MAX_PERIOD_0 = 15'h0055; // 85
  localparam logic [14:0] MAX_PERIOD_1 = 15'h044c; // 1100
  localparam logic [14:0] MAX_PERIOD_2 = 15'h1450; // 5200
  localparam logic [14:0] MAX_PERIOD_3 = 15'h544c; // 21580

  // interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SRCAL_IDLE    = 4'h1,
    SRCAL_WAIT_SR = 4'h2,
    SRCAL_ACCUM   = 4'h4,
    SRCAL_DONE    = 4'h8
  } srcal_state_e;

  typedef struct packed {
    logic [3:0]  wstrb;
    logic        aw_held;
    logic [13:0] awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } srcal_bus_s;

  typedef struct packed {
    srcal_bus_s   bus;
    logic [7:0]   enable;
    logic [7:0]   config_reg;
    logic [23:0]  manual;
    logic [7:0]   ramp;
    logic [1:0]   irq_status;
    logic [1:0]   irq_enable;
    logic         enable_q;
    logic [3:0]   cfg_run;
    srcal_state_e state;
    logic         sr_s1;
    logic         sr_s2;
    logic         sr_s3;
    logic [14:0]  period_cnt;
    logic [8:0]   acc_cnt;
    logic [8:0]   avg_cnt;
    logic [31:0]  phase_sum;
    logic [31:0]  tot_sum;
    logic [31:0]  cyc_cnt;
    logic [16:0]  result;
    logic         done;
  } srcal_state_s;

endpackage

// ===== srcal_top.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps

module srcal_top (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        sysref,
  output logic [16:0]      aperture_delay,
  output logic             irq,
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  srcal_pkg::srcal_state_s r;
  srcal_pkg::srcal_state_s next_r;

  // byte address to register index
  function automatic logic [11:0] reg_index(input logic [13:0] a);
    reg_index = a[13:2];
  endfunction

  // four raised to one plus a 2-bit code: 4, 16, 64, 256
  function automatic logic [8:0] pow4(input logic [1:0] code);
    pow4 = 9'h004 << {code, 1'b0};
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic [14:0] max_period(input logic [1:0] code);
    case (code)
      2'h0:    max_period = srcal_pkg::MAX_PERIOD_0;
      2'h1:    max_period = srcal_pkg::MAX_PERIOD_1;
      2'h2:    max_period = srcal_pkg::MAX_PERIOD_2;
      default: max_period = srcal_pkg::MAX_PERIOD_3;
    endcase
  endfunction

  logic        wr_fire;
  logic        rd_fire;
  logic [11:0] wr_idx;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic        wr_hit;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [11:0] rd_idx;
  logic        en_bit;
  logic        en_rise;
  logic        sr_rise;
  logic [1:0]  ev;
  logic [1:0]  clr;
  logic [1:0]  run_avg;
  logic [1:0]  run_hdur;
  logic [31:0] bound;
  logic [23:0] status_word;

  // ready outputs are combinational, one item in flight per channel
  assign s_axi_awready = !r.bus.aw_held && !r.bus.bvalid;
  assign s_axi_wready  = !r.bus.w_held && !r.bus.bvalid;
  assign s_axi_arready = !r.bus.rvalid;
  assign s_axi_bvalid  = r.bus.bvalid;
  assign s_axi_bresp   = r.bus.bresp;
  assign s_axi_rvalid  = r.bus.rvalid;
  assign s_axi_rdata   = r.bus.rdata;
  assign s_axi_rresp   = r.bus.rresp;

  // run settings latched at the start so mid-run writes are harmless
  assign run_avg  = r.cfg_run[3:2];
  assign run_hdur = r.cfg_run[1:0];
  // exponent reaches 8 for codes 3 and 3, so the sum needs four bits
  assign bound    = 32'(srcal_pkg::BOUND_BASE) << {(4'(run_avg) + 4'(run_hdur) + 4'h2), 1'b0};

  assign en_bit  = r.enable[0];
  assign en_rise = en_bit && !r.enable_q;
  assign sr_rise = r.sr_s2 && !r.sr_s3;

  // completion flag and result, flag masked by the enable level
  assign status_word = {6'h00, r.done && en_bit, r.result};

  // delay mux; manual bits 16..0 include the clock-invert bit
  assign aperture_delay = (en_bit && r.done) ? r.result : (en_bit ? r.result : r.manual[16:0]);
  assign irq = |(r.irq_status & r.irq_enable);

  // write decode, taking address and data in either order
  always_comb begin
    wr_fire = (r.bus.aw_held || s_axi_awvalid) && (r.bus.w_held || s_axi_wvalid) && !r.bus.bvalid;
    wr_idx  = reg_index(r.bus.aw_held ? r.bus.awaddr : s_axi_awaddr);
    wr_hit  = 1'b1;
    wr_old  = 32'h00000000;
    case (wr_idx)
      srcal_pkg::IDX_ENABLE: wr_old = {24'h000000, r.enable};
      srcal_pkg::IDX_CONFIG: wr_old = {24'h000000, r.config_reg};
      srcal_pkg::IDX_MANUAL: wr_old = {8'h00, r.manual};
      srcal_pkg::IDX_RAMP:   wr_old = {24'h000000, r.ramp};
      srcal_pkg::IDX_IRQ_EN: wr_old = {30'h00000000, r.irq_enable};
      srcal_pkg::IDX_IRQ_CL: wr_old = 32'h00000000;
      default:               wr_hit = 1'b0;
    endcase
    // strobes travel with held data, the master may change them once w is taken
    wr_val = merge(wr_old, r.bus.w_held ? r.bus.wdata : s_axi_wdata, r.bus.w_held ? r.bus.wstrb : s_axi_wstrb);
  end

  // read decode
  always_comb begin
    rd_fire = s_axi_arvalid && !r.bus.rvalid;
    rd_idx  = reg_index(s_axi_araddr);
    rd_hit  = 1'b1;
    rd_val  = 32'h00000000;
    case (rd_idx)
      srcal_pkg::IDX_ENABLE: rd_val = {24'h000000, r.enable};
      srcal_pkg::IDX_CONFIG: rd_val = {24'h000000, r.config_reg};
      srcal_pkg::IDX_RESULT: rd_val = {8'h00, status_word};
      srcal_pkg::IDX_MANUAL: rd_val = {8'h00, r.manual};
      srcal_pkg::IDX_RAMP:   rd_val = {24'h000000, r.ramp};
      srcal_pkg::IDX_IRQ_ST: rd_val = {30'h00000000, r.irq_status};
      srcal_pkg::IDX_IRQ_CL: rd_val = 32'h00000000;
      srcal_pkg::IDX_IRQ_EN: rd_val = {30'h00000000, r.irq_enable};
      srcal_pkg::IDX_SYSREF: rd_val = {31'h00000000, r.sr_s2};
      default:               rd_hit = 1'b0;
    endcase
  end

  // next state of bus, registers and calibration engine
  always_comb begin
    next_r = r;
    ev     = 2'h0;
    clr    = 2'h0;

    // write address and data channels
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.bus.aw_held = 1'b1;
      next_r.bus.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.bus.w_held = 1'b1;
      next_r.bus.wdata  = s_axi_wdata;
      next_r.bus.wstrb  = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_r.bus.aw_held = 1'b0;
      next_r.bus.w_held  = 1'b0;
      next_r.bus.bvalid  = 1'b1;
      next_r.bus.bresp   = wr_hit ? srcal_pkg::RESP_OKAY : srcal_pkg::RESP_SLVERR;
      case (wr_idx)
        srcal_pkg::IDX_ENABLE: next_r.enable     = wr_val[7:0];
        srcal_pkg::IDX_CONFIG: next_r.config_reg = wr_val[7:0];
        srcal_pkg::IDX_MANUAL: next_r.manual     = wr_val[23:0];
        srcal_pkg::IDX_RAMP:   next_r.ramp       = wr_val[7:0];
        srcal_pkg::IDX_IRQ_EN: next_r.irq_enable = wr_val[1:0];
        srcal_pkg::IDX_IRQ_CL: clr               = wr_val[1:0];
        default:               next_r.bus.bresp  = srcal_pkg::RESP_SLVERR;
      endcase
    end else if (r.bus.bvalid && s_axi_bready) begin
      next_r.bus.bvalid = 1'b0;
    end

    // read channel, answered one cycle after the address is taken
    if (rd_fire) begin
      next_r.bus.rvalid = 1'b1;
      next_r.bus.rdata  = rd_val;
      next_r.bus.rresp  = rd_hit ? srcal_pkg::RESP_OKAY : srcal_pkg::RESP_SLVERR;
    end else if (r.bus.rvalid && s_axi_rready) begin
      next_r.bus.rvalid = 1'b0;
    end

    // sysref synchroniser; only sr_s2 onward is looked at
    next_r.sr_s1    = sysref;
    next_r.sr_s2    = r.sr_s1;
    next_r.sr_s3    = r.sr_s2;
    next_r.enable_q = en_bit;

    // period counter between sysref edges, saturating
    if (sr_rise) begin
      next_r.period_cnt = 15'h0001;
    end else if (r.period_cnt != 15'h7fff) begin
      next_r.period_cnt = r.period_cnt + 15'h0001;
    end

    // running-time counter for the bound on calibration length
    next_r.cyc_cnt = r.cyc_cnt + 32'h00000001;

    // calibration engine
    case (r.state)
      srcal_pkg::SRCAL_IDLE: begin
        if (en_rise) begin
          next_r.cfg_run   = r.config_reg[3:0];
          next_r.state     = srcal_pkg::SRCAL_WAIT_SR;
          next_r.avg_cnt   = 9'h000;
          next_r.tot_sum   = 32'h00000000;
          next_r.cyc_cnt   = 32'h00000000;
          next_r.done      = 1'b0;
        end
      end
      srcal_pkg::SRCAL_WAIT_SR: begin
        // each measurement starts at a sysref edge and samples phase
        if (sr_rise) begin
          next_r.state     = srcal_pkg::SRCAL_ACCUM;
          next_r.acc_cnt   = 9'h000;
          next_r.phase_sum = 32'h00000000;
        end else if (r.period_cnt > max_period(run_hdur) || r.cyc_cnt >= bound) begin
          ev[srcal_pkg::IRQ_FAIL] = 1'b1;
          next_r.state            = srcal_pkg::SRCAL_DONE;
          next_r.result           = r.manual[16:0];
        end
      end
      srcal_pkg::SRCAL_ACCUM: begin
        // accumulate sysref level over the accumulation window
        next_r.phase_sum = r.phase_sum + 32'(r.sr_s2);
        next_r.acc_cnt   = r.acc_cnt + 9'h001;
        if (r.acc_cnt == pow4(run_hdur) - 9'h001) begin
          next_r.tot_sum = r.tot_sum + r.phase_sum + 32'(r.sr_s2);
          next_r.avg_cnt = r.avg_cnt + 9'h001;
          if (r.avg_cnt == pow4(run_avg) - 9'h001) begin
            next_r.state = srcal_pkg::SRCAL_DONE;
            ev[srcal_pkg::IRQ_DONE] = 1'b1;
            // mean high count scaled into the 17-bit delay code
            next_r.result = 17'((r.tot_sum + r.phase_sum + 32'(r.sr_s2)) >> {(3'(run_avg) + 3'(run_hdur)), 1'b0});
          end else begin
            next_r.state = srcal_pkg::SRCAL_WAIT_SR;
          end
        end
      end
      srcal_pkg::SRCAL_DONE: begin
        next_r.done = 1'b1;
      end
      default: next_r.state = srcal_pkg::SRCAL_IDLE;
    endcase

    // dropping enable aborts any run at once
    if (!en_bit) begin
      next_r.state = srcal_pkg::SRCAL_IDLE;
      next_r.done  = 1'b0;
    end

    // sticky status: a set in the clear cycle wins
    next_r.irq_status = (r.irq_status & ~clr) | ev;
  end

  // single state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r            <= '0;
      r.enable     <= srcal_pkg::RST_ENABLE;
      r.config_reg <= srcal_pkg::RST_CONFIG;
      r.manual     <= srcal_pkg::RST_MANUAL;
      r.ramp       <= srcal_pkg::RST_RAMP;
      r.state      <= srcal_pkg::SRCAL_IDLE;
    end else begin
      r <= next_r;
    end
  end

endmodule // srcal_top

// ===== srcal_chk.sv
`timescale 1ns/100ps
module srcal_chk (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [16:0] aperture_delay,
  input wire logic        irq,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [13:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid
);
  localparam logic [13:0] A_EN  = {srcal_pkg::IDX_ENABLE, 2'h0};
  localparam logic [13:0] A_RES = {srcal_pkg::IDX_RESULT, 2'h0};
  localparam logic [13:0] A_MAN = {srcal_pkg::IDX_MANUAL, 2'h0};
  localparam logic [13:0] A_IEN = {srcal_pkg::IDX_IRQ_EN, 2'h0};
  localparam logic [13:0] A_BAD = 14'hae4;
  logic        wr;
  logic        en_m;
  logic [16:0] man_m;
  logic [1:0]  ie_m;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // write shadow, byte lanes honoured like the design
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en_m  <= 1'b0;
      man_m <= 17'h0;
      ie_m  <= 2'h0;
    end else if (wr) begin
      if (s_axi_awaddr == A_EN && s_axi_wstrb[0]) en_m <= s_axi_wdata[0];
      if (s_axi_awaddr == A_MAN && s_axi_wstrb[0]) man_m[7:0] <= s_axi_wdata[7:0];
      if (s_axi_awaddr == A_MAN && s_axi_wstrb[1]) man_m[15:8] <= s_axi_wdata[15:8];
      if (s_axi_awaddr == A_MAN && s_axi_wstrb[2]) man_m[16] <= s_axi_wdata[16];
      if (s_axi_awaddr == A_IEN && s_axi_wstrb[0]) ie_m <= s_axi_wdata[1:0];
    end
  end
  a_manual_drive: assert property ((!en_m && $stable(man_m)) [*3] |-> aperture_delay == man_m)
    else $error("delay differs from manual value");
  a_run_holds: assert property (en_m && $changed(man_m) |=> $stable(aperture_delay))
    else $error("manual write leaked into running delay");
  a_off_restore: assert property ($fell(en_m) |=> aperture_delay == man_m)
    else $error("delay not restored after disable");
  a_done_gated: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_RES && !en_m
    |=> !s_axi_rdata[17])
    else $error("done flag seen while disabled");
  a_wr_answer: assert property (wr |=> s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_unmapped_err: assert property (wr && s_axi_awaddr == A_BAD |=> s_axi_bresp == srcal_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  a_irq_masked: assert property ((ie_m == 2'h0) [*2] |-> !irq)
    else $error("interrupt high while masked");
  c_start: cover property ($rose(en_m));
  c_irq: cover property (irq);
  c_bad: cover property (wr && s_axi_awaddr == A_BAD);
endmodule // srcal_chk

bind srcal_top srcal_chk srcal_chk_i (.clk_sys(clk_sys), .resetn(resetn), .aperture_delay(aperture_delay),
  .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid));

// ===== srcal_sysref_gen.sv
`timescale 1ns/100ps
module srcal_sysref_gen (
  input wire logic        clk_sys,
  input wire logic        run,
  input wire logic [15:0] period,
  output logic            sysref
);
  logic [15:0] cnt;
  // free period counter; the bench picks the period against the limit
  always_ff @(posedge clk_sys) begin
    if (!run || cnt >= period - 16'h1) cnt <= 16'h0;
    else cnt <= cnt + 16'h1;
  end
  // short high pulse, low while stopped
  assign sysref = run && (cnt < 16'h8);
endmodule // srcal_sysref_gen

// ===== srcal_tb_top.sv
`timescale 1ns/100ps
module srcal_tb_top;
  typedef struct {logic w; logic [13:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} srcal_row_s;
  localparam logic [13:0] A_EN  = {srcal_pkg::IDX_ENABLE, 2'h0};
  localparam logic [13:0] A_CFG = {srcal_pkg::IDX_CONFIG, 2'h0};
  localparam logic [13:0] A_RES = {srcal_pkg::IDX_RESULT, 2'h0};
  localparam logic [13:0] A_MAN = {srcal_pkg::IDX_MANUAL, 2'h0};
  localparam logic [13:0] A_RMP = {srcal_pkg::IDX_RAMP, 2'h0};
  localparam logic [13:0] A_IST = {srcal_pkg::IDX_IRQ_ST, 2'h0};
  localparam logic [13:0] A_ICL = {srcal_pkg::IDX_IRQ_CL, 2'h0};
  localparam logic [13:0] A_IEN = {srcal_pkg::IDX_IRQ_EN, 2'h0};
  localparam logic [13:0] A_BAD = 14'hae4;
  logic        clk_sys, resetn, sysref, irq, sr_run;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [16:0] aperture_delay;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb;
  logic [15:0] period;
  int          mismatches, checks, cyc, t0;
  logic [7:0]  cfgs[4] = '{8'h00, 8'h07, 8'h0a, 8'h0d};
  srcal_row_s  rows[7] = '{'{1'b0, A_EN, 32'h0, 32'h0, 2'h0}, '{1'b0, A_CFG, 32'h0, 32'h05, 2'h0},
    '{1'b0, A_MAN, 32'h0, 32'h0, 2'h0}, '{1'b0, A_RMP, 32'h0, 32'h0, 2'h0},
    '{1'b1, A_MAN, 32'hffff_abcd, 32'h00ff_abcd, 2'h0}, '{1'b1, A_RMP, 32'h0103, 32'h03, 2'h0},
    '{1'b1, A_BAD, 32'h1, 32'h0, srcal_pkg::RESP_SLVERR}};
  srcal_top srcal_top_i (.clk_sys(clk_sys), .resetn(resetn), .sysref(sysref), .aperture_delay(aperture_delay),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  srcal_sysref_gen srcal_sysref_gen_i (.clk_sys(clk_sys), .run(sr_run), .period(period), .sysref(sysref));
  // 200 MHz clock and a free cycle count
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // handshakes judged at the negedge, as ready is combinational
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic ka, kw, b;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk_sys);
      ka = awready;
      kw = wready;
      b = bvalid;
      resp = bresp;
      @(posedge clk_sys);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [13:0] a);
    logic ka, b;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk_sys);
      ka = arready;
      b = rvalid;
      rd_v = rdata;
      resp = rresp;
      @(posedge clk_sys);
      if (ka) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic print_verdict();
    $display("counts: checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog: all runs together need about 33000 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end
  initial begin
    {clk_sys, resetn, sr_run, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wdata, mismatches, checks} = '0;
    wstrb = 4'hf;
    period = 16'd80;
    repeat (16) @(posedge clk_sys);
    chk(aperture_delay, 17'h0);
    resetn <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
        chk(resp, rows[i].r);
      end
      rd(rows[i].a);
      chk(rd_v, rows[i].e);
      chk(resp, rows[i].r);
    end
    $display("test registers done");
    // single byte lane write leaves the other lanes alone
    wstrb <= 4'h1;
    wr(A_MAN, 32'h0000_0012);
    wstrb <= 4'hf;
    rd(A_MAN);
    chk(rd_v, 32'h00ff_ab12);
    chk(aperture_delay, 17'h1ab12);
    wr(A_IEN, 32'h3);
    sr_run <= 1'b1;
    // converter calibration is not modelled here, so it is always idle
    foreach (cfgs[i]) begin
      wr(A_CFG, {24'h0, cfgs[i]});
      wr(A_EN, 32'h1);
      t0 = cyc;
      // first run: late config and manual writes must not disturb it
      if (i == 0) wr(A_CFG, 32'h0f);
      if (i == 0) wr(A_MAN, 32'h5555);
      rd_v = 32'h0;
      while (rd_v[17] !== 1'b1) rd(A_RES);
      chk(cyc - t0 <= 256 * 19 * 4 ** (cfgs[i][3:2] + cfgs[i][1:0] + 2), 1);
      chk(aperture_delay, rd_v[16:0]);
      chk(irq, 1);
      wr(A_EN, 32'h1);
      rd(A_RES);
      chk(rd_v[17], 1);
      if (i == 1) begin
        wr(A_IEN, 32'h0);
        chk(irq, 0);
        wr(A_IEN, 32'h3);
        chk(irq, 1);
      end
      wr(A_ICL, 32'h3);
      chk(irq, 0);
      wr(A_EN, 32'h0);
      chk(aperture_delay, 17'h05555);
      rd(A_RES);
      chk(rd_v[17], 0);
      $display("test calibration %h done", cfgs[i]);
    end
    // period just past the shortest limit must fail over to manual delay
    period <= 16'd90;
    wr(A_CFG, 32'h0);
    wr(A_EN, 32'h1);
    rd_v = 32'h0;
    while (rd_v[17] !== 1'b1) rd(A_RES);
    chk(aperture_delay, 17'h05555);
    rd(A_IST);
    chk(rd_v[1], 1);
    wr(A_EN, 32'h0);
    $display("test period limit done");
    // reset in mid-run returns registers and outputs to their reset values
    wr(A_EN, 32'h1);
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b0;
    @(posedge clk_sys);
    chk(aperture_delay, 17'h0);
    chk(irq, 0);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(A_EN);
    chk(rd_v, 32'h0);
    rd(A_CFG);
    chk(rd_v, 32'h05);
    rd(A_RES);
    chk(rd_v[17], 0);
    $display("test reset done");
    print_verdict();
  end
endmodule // srcal_tb_top
